// ---- bench/dhr_host_model.sv ----
/*
  Host model: starts a record read and collects all 512 bytes,
  stalling on alternate cycles when asked.
  Assumes builder outputs settle just after each mclk edge.
*/
`timescale 1ns/1ns
module dhr_host_model (
  input  wire logic       mclk,
  input  wire logic       recValid,
  input  wire logic       recLast,
  input  wire logic [7:0] recByte,
  input  wire logic [8:0] recIdx,
  output logic            recStart,
  output logic            recReady
);
  logic [7:0] mem [512];
  logic       sumOk;
  logic       lastOk;
  int         got;

  // idle host at time zero
  initial begin
    recStart = 1'b0;
    recReady = 1'b0;
    sumOk    = 1'b0;
    lastOk   = 1'b0;
    got      = 0;
  end

  // read one record; a beat is taken at the edge after ready and valid meet
  task automatic readRec(input logic slow);
    logic [7:0] s;
    int         t;
    s   = 8'h00;
    got = 0;
    lastOk = 1'b1;
    t   = 0;
    @(posedge mclk);
    #1 recStart = 1'b1;
    @(posedge mclk);
    #1 recStart = 1'b0;
    while (got < 512 && t < 2000) begin
      @(posedge mclk);
      #1 recReady = !(slow && t[0]);
      t++;
      if (recReady && recValid === 1'b1) begin
        mem[recIdx] = recByte;
        lastOk      = lastOk && (recLast === (recIdx === 9'h1FF));
        s           = s + recByte;
        got++;
      end
    end
    @(posedge mclk);
    #1 recReady = 1'b0;
    sumOk = (s === 8'h00) && (got == 512); // short or bad-sum record rejected
  endtask
endmodule

// ---- bench/dhr_record_builder_tb.sv ----
/*
  Self-checking bench for the record builder: reads whole records
  through the host model and compares fields with expectations.
  Assumes the package and host model are compiled first.
*/
`timescale 1ns/1ns
module dhr_record_builder_tb;
  localparam int NA = 30;
  logic                   mclk, rst_n, ce, recStart, recReady, recValid;
  logic                   recLast, recBusy, pwrSaveReq, attrSaveDone;
  logic                   attrSaveReq, pwrSaveGrant;
  logic [NA-1:0]          sampleStb, sampleErr;
  logic [7:0]             recByte;
  logic [8:0]             recIdx;
  dhr_pkg::dhr_attr_cfg_s attrCfg [NA];
  dhr_pkg::dhr_health_s   health;
  dhr_pkg::dhr_offl_cap_s offlCap;
  int                     error_cnt, cmp_count, b;
  logic [6:0]             offTbl [5] = '{7'h00, 7'h02, 7'h04, 7'h05, 7'h06};
  logic [3:0]             stTbl [9]  = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};

  dhr_record_builder #(.NUM_ATTR(NA), .WIN(4)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .attrCfg(attrCfg), .sampleStb(sampleStb),
    .sampleErr(sampleErr), .health(health), .offlCap(offlCap), .recStart(recStart),
    .recReady(recReady), .recByte(recByte), .recIdx(recIdx), .recValid(recValid),
    .recLast(recLast), .recBusy(recBusy), .pwrSaveReq(pwrSaveReq),
    .attrSaveDone(attrSaveDone), .attrSaveReq(attrSaveReq), .pwrSaveGrant(pwrSaveGrant)
  );

  dhr_host_model host (
    .mclk(mclk), .recValid(recValid), .recLast(recLast), .recByte(recByte), .recIdx(recIdx),
    .recStart(recStart), .recReady(recReady)
  );

  // 50 MHz clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one cycle of sample strobes with their error qualifiers, then one quiet cycle
  task automatic smp(input logic [NA-1:0] stb, input logic [NA-1:0] err);
    sampleStb = stb;
    sampleErr = err;
    @(posedge mclk);
    #1 sampleStb = '0;
    sampleErr = '0;
    @(posedge mclk);
    #1;
  endtask

  // expected off-line capability byte
  function automatic logic [7:0] capByte(input dhr_pkg::dhr_offl_cap_s c);
    return {1'b0, c.selective, 1'b0, c.selfTest, c.readScan, c.abortOnCmd, c.autoCtl,
            c.immediate};
  endfunction

  // status and capability area of the last record read
  task automatic checkStat();
    chk(host.mem[9'h16A], {health.autoEn, health.offlCode});
    chk(host.mem[9'h16B], {health.stCode, health.stPct});
    chk({host.mem[9'h16D], host.mem[9'h16C]}, health.offlSecs);
    chk(host.mem[9'h16E], 8'h01);
    chk(host.mem[9'h16F], capByte(offlCap));
    chk({host.mem[9'h171], host.mem[9'h170]}, 16'h0003);
    chk(host.mem[9'h172], 8'h01);
    chk(host.mem[9'h174], health.stMinutes);
    chk(host.sumOk, 1'b1);
    chk(host.lastOk, 1'b1);
    chk({recBusy, recValid, recLast}, 3'b000);
  endtask

  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #1_000_000;
    error_cnt++;
    results();
  end

  // test sequence
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    sampleStb = '0;
    sampleErr = '0;
    pwrSaveReq = 1'b0;
    attrSaveDone = 1'b0;
    health = '0;
    health.failPoint = 8'h5A;
    health.stMinutes = 8'h2D;
    health.offlSecs = 16'h1234;
    offlCap = 6'h3F;
    for (int i = 0; i < NA; i++) begin
      attrCfg[i] = '{8'(i + 1), i[0], i[1], i == 0};
    end
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;

    host.readRec(1'b1);
    for (int i = 0; i < NA; i++) begin
      b = 2 + 12 * i;
      chk(host.mem[b], 8'(i + 1));
      chk(host.mem[b + 1], {6'h00, attrCfg[i].onLine, attrCfg[i].preFail});
      chk(host.mem[b + 2], 8'h00);
      chk(host.mem[b + 3], 8'h64);
      chk(host.mem[b + 4], 8'h64);
    end
    chk({host.mem[1], host.mem[0]}, 16'h0010);
    chk(host.mem[9'h173], 8'h00);
    checkStat();
    $display("test reset_record done");

    // strobes while frozen must not count
    ce = 1'b0;
    repeat (4) smp(30'h4, 30'h4);
    ce = 1'b1;
    for (int k = 0; k < 4; k++) smp(30'hF, 30'({(k < 2), (k < 3), 2'b00}));
    host.readRec(1'b0);
    chk(host.mem[5], 8'h65);
    chk(host.mem[17], 8'h64);
    chk(host.mem[29], 8'h63);
    chk(host.mem[30], 8'h63);
    chk(host.mem[31], 8'h03);
    chk(host.mem[41], 8'h64);
    chk(host.mem[43], 8'h02);
    $display("test windows done");

    for (int w = 0; w < 160; w++) repeat (4) smp(30'h11, 30'h10);
    host.readRec(1'b0);
    chk(host.mem[5], 8'hFD);
    chk(host.mem[53], 8'h01);
    $display("test limits done");

    for (int i = 0; i < 9; i++) begin
      health.autoEn = i[0];
      health.offlCode = offTbl[i % 5];
      health.stCode = stTbl[i];
      health.stPct = 4'(9 - i);
      offlCap = i[0] ? 6'h2A : 6'h15;
      host.readRec(1'b0);
      checkStat();
    end
    chk(host.mem[9'h173], 8'h5A);
    // out-of-range firmware codes are reported as their safe values
    health.offlCode = 7'h03;
    health.stCode = 4'h9;
    health.stPct = 4'hC;
    health.failPoint = 8'hA5;
    host.readRec(1'b0);
    chk(host.mem[9'h16A], {health.autoEn, 7'h00});
    chk(host.mem[9'h16B], 8'h39);
    chk(host.mem[9'h173], 8'hA5);
    chk(host.sumOk, 1'b1);
    $display("test status_codes done");

    // a second reset in mid-run brings every value back to its start
    health.stCode = 4'h0;
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    host.readRec(1'b0);
    chk(host.mem[5], 8'h64);
    chk(host.mem[53], 8'h64);
    chk(host.mem[54], 8'h64);
    chk(host.mem[9'h173], 8'h00);
    $display("test mid_reset done");

    pwrSaveReq = 1'b1;
    @(posedge mclk);
    #1 chk({attrSaveReq, pwrSaveGrant}, 2'b10);
    repeat (3) @(posedge mclk);
    #1 chk({attrSaveReq, pwrSaveGrant}, 2'b10);
    attrSaveDone = 1'b1;
    @(posedge mclk);
    #1 attrSaveDone = 1'b0;
    chk({attrSaveReq, pwrSaveGrant}, 2'b01);
    repeat (2) @(posedge mclk);
    #1 chk({attrSaveReq, pwrSaveGrant}, 2'b01);
    pwrSaveReq = 1'b0;
    @(posedge mclk);
    #1 chk({attrSaveReq, pwrSaveGrant}, 2'b00);
    $display("test power_save done");
    results();
  end
endmodule

// ---- hw/dhr_attr_norm.sv ----
/*
  One attribute's normalizer: turns a stream of good/bad samples into a
  normalized value, a worst value and a raw error count.
  Assumes samples come from logic on mclk.
*/
`timescale 1ns/1ns
`include "dhr_defines.svh"

module dhr_attr_norm #(
  parameter int WIN     = `DHR_WIN_SAMPLES,
  parameter int ERR_LIM = `DHR_ERR_LIMIT
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        sampleStb,
  input  wire logic        sampleErr,
  input  wire logic        perfRate,
  output logic [7:0]       normVal,
  output logic [7:0]       worstVal,
  output logic [31:0]      rawCnt
);

  logic [15:0] winCnt_r;
  logic [15:0] errCnt_r;
  logic [7:0]  norm_r;
  logic [7:0]  worst_r;
  logic [31:0] raw_r;
  logic [15:0] errTot;
  logic        winEnd;
  logic [7:0]  ceiling;
  logic [7:0]  norm_nxt;

  // a value moves only on a full window of samples
  assign winEnd  = ce && sampleStb && (winCnt_r == 16'(WIN - 1)); // see [RQ5]
  assign errTot  = errCnt_r + {15'h0000, sampleErr};
  assign ceiling = perfRate ? `DHR_NORM_PERF_MAX : `DHR_NORM_MAX; // see [RQ4]
  assign norm_nxt = (errTot > 16'(ERR_LIM)) ?
                      ((norm_r > `DHR_NORM_MIN) ? norm_r - 8'h01 : norm_r) :
                    (errTot == 16'h0000 && norm_r < ceiling) ? norm_r + 8'h01 :
                    norm_r; // see [RQ3]

  // window counters, value, worst and raw counters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      winCnt_r <= 16'h0000;
      errCnt_r <= 16'h0000;
      norm_r   <= `DHR_NORM_INIT; // see [RQ21]
      worst_r  <= `DHR_NORM_INIT;
      raw_r    <= 32'h0000_0000;
    end else if (ce && sampleStb) begin
      winCnt_r <= winEnd ? 16'h0000 : winCnt_r + 16'h0001;
      errCnt_r <= winEnd ? 16'h0000 : errTot;
      if (winEnd) begin
        norm_r <= norm_nxt;
        if (norm_nxt < worst_r) begin
          worst_r <= norm_nxt;
        end
      end
      if (sampleErr && raw_r != 32'hFFFF_FFFF) begin
        raw_r <= raw_r + 32'h0000_0001;
      end
    end
  end

  assign normVal  = norm_r;
  assign worstVal = worst_r;
  assign rawCnt   = raw_r;

  a_norm_range: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ3]
    norm_r >= `DHR_NORM_MIN && norm_r <= ceiling)
    else $error("normalized value out of range");

  a_norm_window: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ5]
    !$stable(norm_r) |-> $past(winEnd))
    else $error("normalized value moved outside a window end");

endmodule

// ---- hw/dhr_defines.svh ----
/*
  Byte offsets, field positions, fixed values and default counts for the
  drive health record builder.
  Assumes it is included by bare name from the design modules.
*/
`ifndef DHR_DEFINES_SVH
`define DHR_DEFINES_SVH

// record geometry
`define DHR_REC_LAST       9'h1FF
`define DHR_OFS_REV_LO     9'h000
`define DHR_OFS_REV_HI     9'h001
`define DHR_ATTR_BASE      9'h002
`define DHR_ATTR_LEN       9'h00C
`define DHR_NUM_ATTR       30
`define DHR_REV_DEFAULT    16'h0010

// attribute entry byte positions
`define DHR_AO_ID          4'h0
`define DHR_AO_FLAG_LO     4'h1
`define DHR_AO_FLAG_HI     4'h2
`define DHR_AO_NORM        4'h3
`define DHR_AO_WORST       4'h4
`define DHR_AO_RAW0        4'h5
`define DHR_AO_RAW3        4'h8

// status flag bit positions
`define DHR_FLAG_PREFAIL   0
`define DHR_FLAG_ONLINE    1

// status and capability area
`define DHR_OFS_OFFL_STAT  9'h16A
`define DHR_OFS_ST_STAT    9'h16B
`define DHR_OFS_OFFL_SECS  9'h16C
`define DHR_OFS_SEG_PTR    9'h16E
`define DHR_OFS_OFFL_CAP   9'h16F
`define DHR_OFS_SMART_CAP  9'h170
`define DHR_OFS_ERRLOG_CAP 9'h172
`define DHR_OFS_FAIL_PT    9'h173
`define DHR_OFS_ST_MIN     9'h174

// fixed field values
`define DHR_SEG_PTR_VAL    8'h01
`define DHR_SMART_CAP_VAL  16'h0003
`define DHR_ERRLOG_CAP_VAL 8'h01

// normalized value range
`define DHR_NORM_INIT      8'h64
`define DHR_NORM_MIN       8'h01
`define DHR_NORM_MAX       8'h64
`define DHR_NORM_PERF_MAX  8'hFD

// self-test and off-line codes
`define DHR_PCT_MAX        4'h9
`define DHR_ST_FATAL       4'h3
`define DHR_ST_READ_FAIL   4'h7
`define DHR_ST_INPROG      4'hF
`define DHR_OFFL_NEVER     7'h00
`define DHR_OFFL_DONE      7'h02
`define DHR_OFFL_SUSP      7'h04
`define DHR_OFFL_ABORT     7'h05
`define DHR_OFFL_FATAL     7'h06

// statistical window defaults
`define DHR_WIN_SAMPLES    16
`define DHR_ERR_LIMIT      2

`endif

// ---- hw/dhr_pkg.sv ----
/*
  Types shared by the drive health record builder and its testbench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dhr_pkg;

  // per-attribute configuration
  typedef struct packed {
    logic [7:0] id;
    logic       preFail;
    logic       onLine;
    logic       perfRate;
  } dhr_attr_cfg_s;

  // live self-test and off-line status from the drive firmware
  typedef struct packed {
    logic        autoEn;
    logic [6:0]  offlCode;
    logic [3:0]  stCode;
    logic [3:0]  stPct;
    logic [15:0] offlSecs;
    logic [7:0]  failPoint;
    logic [7:0]  stMinutes;
  } dhr_health_s;

  // off-line capability feature set
  typedef struct packed {
    logic immediate;
    logic autoCtl;
    logic abortOnCmd;
    logic readScan;
    logic selfTest;
    logic selective;
  } dhr_offl_cap_s;

  typedef enum logic {DHR_RD_IDLE, DHR_RD_SEND} dhr_rd_e;

  typedef enum logic [1:0] {DHR_SV_IDLE, DHR_SV_SAVE, DHR_SV_GRANT} dhr_save_e;

endpackage

// ---- hw/dhr_record_builder.sv ----
/*
  Drive health record builder: streams the 512-byte attribute and status
  record, one byte per accepted beat, ending in the checksum byte.
  Assumes every input comes from logic on mclk, so no synchronisers are
  used; the reader holds recReady low to stall.
  // Summary of operation
  // [RQ1] status flag bit 0: clear advisory end of life, set pre-failure
  // [RQ2] status flag bit 1: clear off-line only, set on-line updated
  // [RQ3] normalized values run from 01h up to 64h
  // [RQ4] performance and error-rate attributes may reach FDh
  // [RQ5] a value moves only after a full statistical window of samples
  // [RQ6] off-line status bit 7 shows automatic collection enabled
  // [RQ7] off-line status code is 0, 2, 4, 5 or 6
  // [RQ8] self-test remaining percent nibble is 0 through 9 only
  // [RQ9] self-test outcome nibble codes 0 to 7 and 15
  // [RQ10] off-line collection time in seconds is reported
  // [RQ11] current segment pointer always reads 01h
  // [RQ12] off-line capability bits 0,1,3,4,6 features; bits 5,7 zero
  // [RQ13] capability bit 2: set aborts on command, clear suspends
  // [RQ14] monitoring capability word reads 0003h
  // [RQ15] attributes are saved before standby or sleep; bits 2-15 zero
  // [RQ16] capability bit 1 means autosave control command supported
  // [RQ17] error logging byte reads 01h, bits 7-1 zero
  // [RQ18] failing self-test section is recorded in its own byte
  // [RQ19] minimum self-test time in minutes is reported
  // [RQ20] last byte makes all 512 bytes sum to zero
  // [RQ21] each normalized value starts at 64h
  // [RQ22] a record not summing to zero is rejected by the host
*/
`timescale 1ns/1ns
`include "dhr_defines.svh"

module dhr_record_builder #(
  parameter int          NUM_ATTR = `DHR_NUM_ATTR,
  parameter int          WIN      = `DHR_WIN_SAMPLES,
  parameter int          ERR_LIM  = `DHR_ERR_LIMIT,
  parameter logic [15:0] REV      = `DHR_REV_DEFAULT
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  dhr_pkg::dhr_attr_cfg_s      attrCfg [NUM_ATTR],
  input  wire logic [NUM_ATTR-1:0]    sampleStb,
  input  wire logic [NUM_ATTR-1:0]    sampleErr,
  input  dhr_pkg::dhr_health_s        health,
  input  dhr_pkg::dhr_offl_cap_s      offlCap,
  input  wire logic                   recStart,
  input  wire logic                   recReady,
  output logic [7:0]                  recByte,
  output logic [8:0]                  recIdx,
  output logic                        recValid,
  output logic                        recLast,
  output logic                        recBusy,
  input  wire logic                   pwrSaveReq,
  input  wire logic                   attrSaveDone,
  output logic                        attrSaveReq,
  output logic                        pwrSaveGrant
);

  localparam logic [8:0] ATTR_END = 9'(`DHR_ATTR_BASE + NUM_ATTR * `DHR_ATTR_LEN);

  dhr_pkg::dhr_rd_e   rdState_r;
  dhr_pkg::dhr_save_e svState_r;
  logic [8:0]  idx_r;
  logic [7:0]  byte_r;
  logic [7:0]  sum_r;
  logic [7:0]  failPoint_r;
  logic [7:0]  normVal  [NUM_ATTR];
  logic [7:0]  worstVal [NUM_ATTR];
  logic [31:0] rawCnt   [NUM_ATTR];

  // one normalizer per attribute
  genvar g;
  generate
    for (g = 0; g < NUM_ATTR; g++) begin : gAttr
      dhr_attr_norm #(
        .WIN     (WIN),
        .ERR_LIM (ERR_LIM)
      ) uNorm (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .sampleStb (sampleStb[g]),
        .sampleErr (sampleErr[g]),
        .perfRate  (attrCfg[g].perfRate),
        .normVal   (normVal[g]),
        .worstVal  (worstVal[g]),
        .rawCnt    (rawCnt[g])
      );
    end
  endgenerate

  // status conditioning: illegal firmware codes never reach the record
  logic [3:0] stPctQ;
  logic [3:0] stCodeQ;
  logic       stFailing;
  logic       offlLegal;
  logic [6:0] offlCodeQ;
  logic [7:0] offlStatByte;
  logic [7:0] stStatByte;
  logic [7:0] offlCapByte;
  logic [15:0] smartCapWord;

  assign stPctQ   = (health.stPct > `DHR_PCT_MAX) ? `DHR_PCT_MAX : health.stPct; // see [RQ8]
  assign stCodeQ  = (health.stCode <= `DHR_ST_READ_FAIL || health.stCode == `DHR_ST_INPROG) ?
                    health.stCode : `DHR_ST_FATAL; // see [RQ9]
  assign stFailing = stCodeQ >= `DHR_ST_FATAL && stCodeQ <= `DHR_ST_READ_FAIL;
  assign offlLegal = health.offlCode == `DHR_OFFL_NEVER || health.offlCode == `DHR_OFFL_DONE ||
                     health.offlCode == `DHR_OFFL_SUSP || health.offlCode == `DHR_OFFL_ABORT ||
                     health.offlCode == `DHR_OFFL_FATAL;
  assign offlCodeQ = offlLegal ? health.offlCode : `DHR_OFFL_NEVER; // see [RQ7]
  assign offlStatByte = {health.autoEn, offlCodeQ}; // see [RQ6]
  assign stStatByte   = {stCodeQ, stPctQ}; // see [RQ8] see [RQ9]
  // bits 5 and 7 held at zero
  assign offlCapByte  = {1'b0, offlCap.selective, 1'b0, offlCap.selfTest,
                         offlCap.readScan, offlCap.abortOnCmd,
                         offlCap.autoCtl, offlCap.immediate}; // see [RQ12] see [RQ13]
  assign smartCapWord = `DHR_SMART_CAP_VAL; // see [RQ14] see [RQ16]

  // section of a failed self-test, held until the next failure
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      failPoint_r <= 8'h00;
    end else if (ce && stFailing) begin
      failPoint_r <= health.failPoint; // see [RQ18]
    end
  end

  // byte selection for the index about to be loaded
  logic       idle;
  logic       accept;
  logic [8:0] nextIdx;
  logic [8:0] rel;
  logic [4:0] attrSel;
  logic [3:0] attrOfs;
  logic       inAttr;
  logic [7:0] attrByte;
  logic [7:0] statByte;
  logic [7:0] selByte;
  logic [7:0] sumNext;
  logic [31:0] rawSel;
  dhr_pkg::dhr_attr_cfg_s cfgSel;

  assign idle    = rdState_r == dhr_pkg::DHR_RD_IDLE;
  assign accept  = ce && !idle && recReady;
  assign nextIdx = idle ? 9'h000 : idx_r + 9'h001;
  assign rel     = nextIdx - `DHR_ATTR_BASE;
  assign attrSel = 5'(rel / `DHR_ATTR_LEN);
  assign attrOfs = 4'(rel % `DHR_ATTR_LEN);
  assign inAttr  = nextIdx >= `DHR_ATTR_BASE && nextIdx < ATTR_END;
  assign cfgSel  = attrCfg[attrSel];
  assign rawSel  = rawCnt[attrSel];

  assign attrByte =
    (attrOfs == `DHR_AO_ID)      ? cfgSel.id :
    (attrOfs == `DHR_AO_FLAG_LO) ? {6'h00, cfgSel.onLine, cfgSel.preFail} : // see [RQ1] see [RQ2]
    (attrOfs == `DHR_AO_NORM)    ? normVal[attrSel] : // see [RQ3]
    (attrOfs == `DHR_AO_WORST)   ? worstVal[attrSel] :
    (attrOfs >= `DHR_AO_RAW0 && attrOfs <= `DHR_AO_RAW3) ?
      8'(rawSel >> {attrOfs - `DHR_AO_RAW0, 3'h0}) :
    8'h00; // upper status flag byte, raw top bytes and reserved byte

  assign statByte =
    (nextIdx == `DHR_OFS_REV_LO)         ? REV[7:0] :
    (nextIdx == `DHR_OFS_REV_HI)         ? REV[15:8] :
    (nextIdx == `DHR_OFS_OFFL_STAT)      ? offlStatByte :
    (nextIdx == `DHR_OFS_ST_STAT)        ? stStatByte :
    (nextIdx == `DHR_OFS_OFFL_SECS)      ? health.offlSecs[7:0] : // see [RQ10]
    (nextIdx == `DHR_OFS_OFFL_SECS + 9'h001) ? health.offlSecs[15:8] :
    (nextIdx == `DHR_OFS_SEG_PTR)        ? `DHR_SEG_PTR_VAL : // see [RQ11]
    (nextIdx == `DHR_OFS_OFFL_CAP)       ? offlCapByte :
    (nextIdx == `DHR_OFS_SMART_CAP)      ? smartCapWord[7:0] :
    (nextIdx == `DHR_OFS_SMART_CAP + 9'h001) ? smartCapWord[15:8] : // see [RQ15]
    (nextIdx == `DHR_OFS_ERRLOG_CAP)     ? `DHR_ERRLOG_CAP_VAL : // see [RQ17]
    (nextIdx == `DHR_OFS_FAIL_PT)        ? failPoint_r :
    (nextIdx == `DHR_OFS_ST_MIN)         ? health.stMinutes : // see [RQ19]
    8'h00;

  // checksum byte closes the sum of everything already sent
  assign sumNext = idle ? 8'h00 : sum_r + byte_r;
  assign selByte = (nextIdx == `DHR_REC_LAST) ? 8'h00 - sumNext : // see [RQ20] see [RQ22]
                   inAttr ? attrByte : statByte;

  // record streamer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdState_r <= dhr_pkg::DHR_RD_IDLE;
      idx_r     <= 9'h000;
      byte_r    <= 8'h00;
      sum_r     <= 8'h00;
    end else if (ce && ((idle && recStart) || (accept && idx_r != `DHR_REC_LAST))) begin
      rdState_r <= dhr_pkg::DHR_RD_SEND;
      idx_r     <= nextIdx;
      byte_r    <= selByte;
      sum_r     <= sumNext;
    end else if (accept) begin
      rdState_r <= dhr_pkg::DHR_RD_IDLE;
    end
  end

  assign recByte  = byte_r;
  assign recIdx   = idx_r;
  assign recValid = !idle;
  assign recBusy  = !idle;
  assign recLast  = !idle && idx_r == `DHR_REC_LAST;

  // attributes are saved before power saving is granted
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      svState_r <= dhr_pkg::DHR_SV_IDLE;
    end else if (ce) begin
      unique case (svState_r)
        dhr_pkg::DHR_SV_IDLE: begin
          if (pwrSaveReq) begin
            svState_r <= dhr_pkg::DHR_SV_SAVE;
          end
        end
        dhr_pkg::DHR_SV_SAVE: begin
          if (attrSaveDone) begin
            svState_r <= dhr_pkg::DHR_SV_GRANT; // see [RQ15]
          end
        end
        dhr_pkg::DHR_SV_GRANT: begin
          if (!pwrSaveReq) begin
            svState_r <= dhr_pkg::DHR_SV_IDLE;
          end
        end
        default: begin
          svState_r <= dhr_pkg::DHR_SV_IDLE;
        end
      endcase
    end
  end

  assign attrSaveReq  = svState_r == dhr_pkg::DHR_SV_SAVE;
  assign pwrSaveGrant = svState_r == dhr_pkg::DHR_SV_GRANT;

  a_csum_zero: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ20]
    recLast |-> 8'(sum_r + byte_r) == 8'h00)
    else $error("record bytes do not sum to zero");

  a_pct_legal: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ8]
    recValid && recIdx == `DHR_OFS_ST_STAT |-> recByte[3:0] <= `DHR_PCT_MAX)
    else $error("self-test percent above nine");

  a_seg_ptr: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ11]
    recValid && recIdx == `DHR_OFS_SEG_PTR |-> recByte == `DHR_SEG_PTR_VAL)
    else $error("segment pointer not one");

  a_cap_word: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ14]
    recValid && recIdx == `DHR_OFS_SMART_CAP && accept
      |=> recIdx == `DHR_OFS_SMART_CAP + 9'h001 && recByte == 8'h00 && $past(recByte) == 8'h03)
    else $error("monitoring capability word not 0003h");

  a_offl_cap: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ12]
    recValid && recIdx == `DHR_OFS_OFFL_CAP |-> !recByte[5] && !recByte[7])
    else $error("reserved off-line capability bits set");

  a_errlog_cap: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ17]
    recValid && recIdx == `DHR_OFS_ERRLOG_CAP |-> recByte == `DHR_ERRLOG_CAP_VAL)
    else $error("error logging capability not 01h");

  a_save_grant: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ15]
    $rose(pwrSaveGrant) |-> $past(attrSaveDone) && $past(attrSaveReq))
    else $error("power saving granted before attributes saved");

  // stream handshake: a stalled byte stands, accepted bytes step by one
  a_byte_stall: assert property (@(posedge mclk) disable iff (!rst_n)
    recValid && !accept |=> $stable(recByte) && $stable(recIdx))
    else $error("record byte moved while stalled");

  a_idx_step: assert property (@(posedge mclk) disable iff (!rst_n)
    accept && !recLast |=> recValid && recIdx == $past(recIdx) + 9'h001)
    else $error("record index did not advance by one");

  a_last_release: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ20]
    accept && recLast |=> !recValid)
    else $error("stream still valid after the checksum byte");

  // status bytes carry only the legal codes, the auto enable bit and the latched failing section
  a_offl_code: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ7]
    recValid && recIdx == `DHR_OFS_OFFL_STAT |->
      recByte[6:0] == `DHR_OFFL_NEVER || recByte[6:0] == `DHR_OFFL_DONE ||
      recByte[6:0] == `DHR_OFFL_SUSP || recByte[6:0] == `DHR_OFFL_ABORT ||
      recByte[6:0] == `DHR_OFFL_FATAL)
    else $error("illegal off-line status code");

  a_st_code: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ9]
    recValid && recIdx == `DHR_OFS_ST_STAT |->
      recByte[7:4] <= `DHR_ST_READ_FAIL || recByte[7:4] == `DHR_ST_INPROG)
    else $error("illegal self-test outcome code");

  a_auto_bit: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ6]
    recValid && recIdx == `DHR_OFS_OFFL_STAT && $changed(recIdx) |->
      recByte[7] == $past(health.autoEn))
    else $error("automatic collection bit does not follow its enable");

  a_fail_latch: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ18]
    ce && stFailing |=> failPoint_r == $past(health.failPoint))
    else $error("failing self-test section not recorded");

  // power save and reset behaviour
  a_grant_hold: assert property (@(posedge mclk) disable iff (!rst_n) // see [RQ15]
    pwrSaveGrant && pwrSaveReq |=> pwrSaveGrant)
    else $error("power saving grant dropped while requested");

  a_reset_idle: assert property (@(posedge mclk)
    !rst_n |=> !recValid && !attrSaveReq && !pwrSaveGrant)
    else $error("outputs not idle after reset");

endmodule
